// file: common/hsp_map.svh
// Constants for the hub strap and status pin block
// Assumes inclusion by the strap block
`ifndef HSP_MAP_SVH
`define HSP_MAP_SVH
`define HSP_PORT_COUNT      4
`define HSP_MODE_I2C        1'b1
`define HSP_MODE_SMBUS      1'b0
`define HSP_POL_ACTIVE_LOW  1'b0
`define HSP_POL_ACTIVE_HIGH 1'b1
`define HSP_POWER_INDIVIDUAL 1'b0
`define HSP_POWER_GANGED    1'b1
`endif

// file: common/hsp_pkg.sv
// Types for the hub strap and status pin block
// Assumes nothing of its surroundings
package hsp_pkg;
  typedef enum logic [2:0] {
    HSP_RESET  = 3'b001,
    HSP_SAMPLE = 3'b010,
    HSP_RUN    = 3'b100
  } hsp_state_t;

  typedef struct packed {
    hsp_state_t state;
    logic [1:0] mode_sync;
    logic [1:0] pol_sync;
    logic [1:0] billboard_enable_pin_sync;
    logic [1:0] cfg0_sync;
    logic [1:0] cfg1_sync;
    logic       i2c_mode;
    logic       polarity;
    logic       ganged;
    logic       full_auto;
    logic       no_power_switch;
    logic       auto_enable_n;
    logic [1:0] configured;
    logic       billboard_on;
    logic [3:0] power_switch;
    logic [3:0] oe;
    logic [3:0] drive;
  } hsp_state_reg_t;
endpackage : hsp_pkg

// file: hw/hsp_strap_pins.sv
// Hub strap sampling and status indicator pin logic
// Assumes straps on pins, a host supplying overrides, one 200 MHz clock
// Behaviour
// - Sample mode strap at reset release
// - Mode pin shows superspeed suspend when enabled
// - Polarity strap sets power output polarity
// - I2C mode: billboard pin enables billboard
// - SMBus mode: billboard from host bit
// - SMBus status: billboard pin shows high-speed
// - SMBus: billboard strap picks ganged power
// - Config pins or host fields give state
// - Charging on: config zero sets full-auto
// - Charging off: config zero disables switching
// - SMBus status: config zero shows superspeed
// - SMBus: config one sets auto-enable bit
// - SMBus status: config one shows Upstream_high_speed_suspend_indicator
`timescale 1ns/1ps
`include "hsp_map.svh"
module hsp_strap_pins
  import hsp_pkg::*;
#(
  parameter int PORTS = `HSP_PORT_COUNT
) (
  input  wire logic             CLK_IN,
  input  wire logic             SYS_RST_IN,
  input  wire logic             MODE_PIN_IN,
  input  wire logic             POLARITY_PIN_IN,
  input  wire logic             BILLBOARD_ENABLE_PIN_PIN_IN,
  input  wire logic             CFG0_PIN_IN,
  input  wire logic             CFG1_PIN_IN,
  input  wire logic             STATUS_OUTPUT_ENABLE_IN,
  input  wire logic             CHARGING_ENABLED_IN,
  input  wire logic             HOST_BILLBOARD_ENABLE_IN,
  input  wire logic [1:0]       HOST_CONFIGURED_IN,
  input  wire logic             HOST_GANGED_WE_IN,
  input  wire logic             HOST_GANGED_IN,
  input  wire logic             HOST_FULL_AUTO_WE_IN,
  input  wire logic             HOST_FULL_AUTO_IN,
  input  wire logic             HOST_NO_SWITCH_WE_IN,
  input  wire logic             HOST_NO_SWITCH_IN,
  input  wire logic             HOST_AUTO_EN_N_WE_IN,
  input  wire logic             HOST_AUTO_EN_N_IN,
  input  wire logic [PORTS-1:0] PORT_POWER_ON_IN,
  input  wire logic             UP_SS_SUSPEND_IN,
  input  wire logic             UP_HS_CONNECT_IN,
  input  wire logic             UP_SS_CONNECT_IN,
  input  wire logic             UP_UPSTREAM_HIGH_SPEED_SUSPEND_INDICATOR_IN,
  output logic                  I2C_MODE_OUT,
  output logic                  BILLBOARD_ENABLE_OUT,
  output logic [1:0]            BILLBOARD_CONFIGURED_OUT,
  output logic                  GANGED_POWER_OUT,
  output logic                  FULL_AUTO_CHARGE_OUT,
  output logic                  POWER_SWITCH_DISABLE_OUT,
  output logic                  AUTO_CHARGE_ENABLE_N_OUT,
  output logic [PORTS-1:0]      PORT_POWER_SWITCH_OUT,
  output logic                  MODE_PIN_OUT,
  output logic                  MODE_PIN_OE_OUT,
  output logic                  BILLBOARD_ENABLE_PIN_PIN_OUT,
  output logic                  BILLBOARD_ENABLE_PIN_PIN_OE_OUT,
  output logic                  CFG0_PIN_OUT,
  output logic                  CFG0_PIN_OE_OUT,
  output logic                  CFG1_PIN_OUT,
  output logic                  CFG1_PIN_OE_OUT
);

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  hsp_state_reg_t s_reg;
  hsp_state_reg_t s_next;
  logic           smbus_status;

  always_comb begin
    s_next = s_reg;
    smbus_status = !s_reg.i2c_mode && STATUS_OUTPUT_ENABLE_IN;
    case (s_reg.state)
      HSP_RESET: begin
        s_next.state = HSP_SAMPLE;
      end
      HSP_SAMPLE: begin
        // Synchronisers already filled during reset; latch the straps
        s_next.state      = HSP_RUN;
        s_next.i2c_mode   = s_reg.mode_sync[1];
        s_next.polarity   = s_reg.pol_sync[1];
        s_next.ganged     = s_reg.billboard_enable_pin_sync[1];
        if (CHARGING_ENABLED_IN) begin
          s_next.full_auto = s_reg.cfg0_sync[1];
        end else begin
          s_next.no_power_switch = s_reg.cfg0_sync[1];
        end
        s_next.auto_enable_n = s_reg.cfg1_sync[1];
      end
      HSP_RUN: begin
        if (HOST_GANGED_WE_IN) s_next.ganged = HOST_GANGED_IN;
        if (HOST_FULL_AUTO_WE_IN) s_next.full_auto = HOST_FULL_AUTO_IN;
        if (HOST_NO_SWITCH_WE_IN) s_next.no_power_switch = HOST_NO_SWITCH_IN;
        if (HOST_AUTO_EN_N_WE_IN) s_next.auto_enable_n = HOST_AUTO_EN_N_IN;
      end
      default: begin
        s_next.state = HSP_RESET;
      end
    endcase
    if (s_reg.state == HSP_RUN) begin
      if (s_reg.i2c_mode) begin
        s_next.billboard_on = s_reg.billboard_enable_pin_sync[1];
        s_next.configured   = {s_reg.cfg1_sync[1], s_reg.cfg0_sync[1]};
      end else begin
        s_next.billboard_on = HOST_BILLBOARD_ENABLE_IN;
        s_next.configured   = HOST_CONFIGURED_IN;
      end
      // Polarity applies to every port output
      s_next.power_switch = s_reg.polarity ? PORT_POWER_ON_IN
                                           : ~PORT_POWER_ON_IN;
      s_next.oe    = {smbus_status, smbus_status, smbus_status,
                      STATUS_OUTPUT_ENABLE_IN};
      s_next.drive = {UP_UPSTREAM_HIGH_SPEED_SUSPEND_INDICATOR_IN, UP_SS_CONNECT_IN,
                      UP_HS_CONNECT_IN, UP_SS_SUSPEND_IN};
    end else begin
      s_next.oe           = 4'h0;
      s_next.drive        = 4'h0;
      s_next.billboard_on = 1'b0;
    end
    if (SYS_RST_IN) begin
      s_next       = '0;
      s_next.state = HSP_RESET;
      s_next.power_switch = 4'h0;
    end
    // Synchronisers keep shifting through reset, so that the strap levels
    // are settled in stage two by the time the sample step reads them
    s_next.mode_sync = {s_reg.mode_sync[0], MODE_PIN_IN};
    s_next.pol_sync  = {s_reg.pol_sync[0], POLARITY_PIN_IN};
    s_next.billboard_enable_pin_sync = {s_reg.billboard_enable_pin_sync[0], BILLBOARD_ENABLE_PIN_PIN_IN};
    s_next.cfg0_sync = {s_reg.cfg0_sync[0], CFG0_PIN_IN};
    s_next.cfg1_sync = {s_reg.cfg1_sync[0], CFG1_PIN_IN};
  end

  always_ff @(posedge CLK_IN) begin
    s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign I2C_MODE_OUT             = s_reg.i2c_mode;
  assign BILLBOARD_ENABLE_OUT     = s_reg.billboard_on;
  assign BILLBOARD_CONFIGURED_OUT = s_reg.configured;
  assign GANGED_POWER_OUT         = s_reg.ganged;
  assign FULL_AUTO_CHARGE_OUT     = s_reg.full_auto;
  assign POWER_SWITCH_DISABLE_OUT = s_reg.no_power_switch;
  assign AUTO_CHARGE_ENABLE_N_OUT = s_reg.auto_enable_n;
  assign PORT_POWER_SWITCH_OUT    = s_reg.power_switch;
  assign MODE_PIN_OUT             = s_reg.drive[0];
  assign MODE_PIN_OE_OUT          = s_reg.oe[0];
  assign BILLBOARD_ENABLE_PIN_PIN_OUT             = s_reg.drive[1];
  assign BILLBOARD_ENABLE_PIN_PIN_OE_OUT          = s_reg.oe[1];
  assign CFG0_PIN_OUT             = s_reg.drive[2];
  assign CFG0_PIN_OE_OUT          = s_reg.oe[2];
  assign CFG1_PIN_OUT             = s_reg.drive[3];
  assign CFG1_PIN_OE_OUT          = s_reg.oe[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_sample_step;
    s_reg.state == HSP_SAMPLE;
  endsequence

  a_mode_latch: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    seq_sample_step |=> I2C_MODE_OUT == $past(s_reg.mode_sync[1]))
    else $error("mode strap not latched");
  a_ss_suspend: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && STATUS_OUTPUT_ENABLE_IN) |=> MODE_PIN_OE_OUT
      && MODE_PIN_OUT == $past(UP_SS_SUSPEND_IN))
    else $error("suspend indicator wrong");
  a_polarity_use: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN) |=> PORT_POWER_SWITCH_OUT ==
      ($past(s_reg.polarity) ? $past(PORT_POWER_ON_IN) : ~$past(PORT_POWER_ON_IN)))
    else $error("power polarity wrong");
  a_bb_i2c: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && s_reg.i2c_mode) |=>
      BILLBOARD_ENABLE_OUT == $past(s_reg.billboard_enable_pin_sync[1]))
    else $error("billboard pin not followed");
  a_bb_smbus: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && !s_reg.i2c_mode) |=>
      BILLBOARD_ENABLE_OUT == $past(HOST_BILLBOARD_ENABLE_IN))
    else $error("billboard host bit not followed");
  a_upstream_high_speed_indicator: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && smbus_status) |=> BILLBOARD_ENABLE_PIN_PIN_OE_OUT
      && BILLBOARD_ENABLE_PIN_PIN_OUT == $past(UP_HS_CONNECT_IN))
    else $error("hs connect indicator wrong");
  a_ganged_latch: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    seq_sample_step |=> GANGED_POWER_OUT == $past(s_reg.billboard_enable_pin_sync[1]))
    else $error("ganged strap not latched");
  a_cfg_state: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && !s_reg.i2c_mode) |=>
      BILLBOARD_CONFIGURED_OUT == $past(HOST_CONFIGURED_IN))
    else $error("configured field wrong");
  a_cfg_pins: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && s_reg.i2c_mode) |=> BILLBOARD_CONFIGURED_OUT ==
      {$past(s_reg.cfg1_sync[1]), $past(s_reg.cfg0_sync[1])})
    else $error("configured pins not followed");
  a_full_auto: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_SAMPLE && CHARGING_ENABLED_IN) |=>
      FULL_AUTO_CHARGE_OUT == $past(s_reg.cfg0_sync[1]))
    else $error("full auto strap not latched");
  a_switch_latch: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_SAMPLE && !CHARGING_ENABLED_IN) |=>
      POWER_SWITCH_DISABLE_OUT == $past(s_reg.cfg0_sync[1]))
    else $error("switch strap not latched");
  a_auto_latch: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    seq_sample_step |=> AUTO_CHARGE_ENABLE_N_OUT == $past(s_reg.cfg1_sync[1]))
    else $error("auto enable strap not latched");
  a_ss_up: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && smbus_status) |=> CFG0_PIN_OE_OUT
      && CFG0_PIN_OUT == $past(UP_SS_CONNECT_IN))
    else $error("ss connect indicator wrong");
  a_upstream_high_speed_suspend_indicator: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (s_reg.state == HSP_RUN && smbus_status) |=> CFG1_PIN_OE_OUT
      && CFG1_PIN_OUT == $past(UP_UPSTREAM_HIGH_SPEED_SUSPEND_INDICATOR_IN))
    else $error("upstream_high_speed_suspend_indicator indicator wrong");
  a_no_drive: assert property (@(posedge CLK_IN)
    (SYS_RST_IN || !STATUS_OUTPUT_ENABLE_IN) |=> !MODE_PIN_OE_OUT
      && !BILLBOARD_ENABLE_PIN_PIN_OE_OUT && !CFG0_PIN_OE_OUT && !CFG1_PIN_OE_OUT)
    else $error("strap pin driven while disabled");

endmodule : hsp_strap_pins

// file: test/hsp_board_model.sv
// Board side of the strap pins: strap resistors that set each pin's level
// Assumes the device output enables are high while the device drives a pin
`timescale 1ns/1ps
module hsp_board_model (
  input  wire logic [4:0] strap_in,
  input  wire logic [3:0] drive_in,
  input  wire logic [3:0] oe_in,
  output logic      [4:0] pin_out
);
  // ----------------------------------------
  // Pin level: device drive wins over strap
  // ----------------------------------------
  // Order of strap_in: mode, polarity, billboard, config zero, config one
  always_comb begin
    pin_out[4] = oe_in[3] ? drive_in[3] : strap_in[4];
    pin_out[3] = strap_in[3];
    pin_out[2] = oe_in[2] ? drive_in[2] : strap_in[2];
    pin_out[1] = oe_in[1] ? drive_in[1] : strap_in[1];
    pin_out[0] = oe_in[0] ? drive_in[0] : strap_in[0];
  end
endmodule : hsp_board_model

// file: test/tb_hsp_strap_pins.sv
// Self-checking bench for the strap and status pin block
// Assumes the board model resolves pin levels from straps and device drive
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_hsp_strap_pins;
  import hsp_pkg::*;
  logic clk, rst, sts_en, chg, host_bb, i2c, bb_en, gang, fa, psd, aen;
  logic [4:0] strap, pin;
  logic [3:0] we, wd, pwr_req, up, psw, pdrv, poe;
  logic [1:0] host_cfg, bb_cfg;
  int         failures, checks_done;
  hsp_board_model u_board (.strap_in(strap), .drive_in(pdrv), .oe_in(poe), .pin_out(pin));
  hsp_strap_pins u_dut (.CLK_IN(clk), .SYS_RST_IN(rst),
    .MODE_PIN_IN(pin[4]), .POLARITY_PIN_IN(pin[3]), .BILLBOARD_ENABLE_PIN_PIN_IN(pin[2]),
    .CFG0_PIN_IN(pin[1]), .CFG1_PIN_IN(pin[0]), .STATUS_OUTPUT_ENABLE_IN(sts_en),
    .CHARGING_ENABLED_IN(chg), .HOST_BILLBOARD_ENABLE_IN(host_bb),
    .HOST_CONFIGURED_IN(host_cfg), .HOST_GANGED_WE_IN(we[3]), .HOST_GANGED_IN(wd[3]),
    .HOST_FULL_AUTO_WE_IN(we[2]), .HOST_FULL_AUTO_IN(wd[2]),
    .HOST_NO_SWITCH_WE_IN(we[1]), .HOST_NO_SWITCH_IN(wd[1]),
    .HOST_AUTO_EN_N_WE_IN(we[0]), .HOST_AUTO_EN_N_IN(wd[0]),
    .PORT_POWER_ON_IN(pwr_req), .UP_SS_SUSPEND_IN(up[3]), .UP_HS_CONNECT_IN(up[2]),
    .UP_SS_CONNECT_IN(up[1]), .UP_UPSTREAM_HIGH_SPEED_SUSPEND_INDICATOR_IN(up[0]), .I2C_MODE_OUT(i2c),
    .BILLBOARD_ENABLE_OUT(bb_en), .BILLBOARD_CONFIGURED_OUT(bb_cfg),
    .GANGED_POWER_OUT(gang), .FULL_AUTO_CHARGE_OUT(fa), .POWER_SWITCH_DISABLE_OUT(psd),
    .AUTO_CHARGE_ENABLE_N_OUT(aen), .PORT_POWER_SWITCH_OUT(psw),
    .MODE_PIN_OUT(pdrv[3]), .MODE_PIN_OE_OUT(poe[3]), .BILLBOARD_ENABLE_PIN_PIN_OUT(pdrv[2]),
    .BILLBOARD_ENABLE_PIN_PIN_OE_OUT(poe[2]), .CFG0_PIN_OUT(pdrv[1]), .CFG0_PIN_OE_OUT(poe[1]),
    .CFG1_PIN_OUT(pdrv[0]), .CFG1_PIN_OE_OUT(poe[0]));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Reset for 10 cycles with given straps, then run into the run state
  task automatic boot(input logic [4:0] s, input logic c);
    @(posedge clk);
    strap <= s;
    chg   <= c;
    rst   <= 1'b1;
    tick(9);
    `CHK("oe_in_reset", 4'h0, poe)
    @(posedge clk);
    rst <= 1'b0;
    tick(5);
  endtask : boot
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_i2c;
    boot(5'h1d, 1'b0);
    `CHK("i2c_mode", 1'b1, i2c)
    `CHK("bb_enable", 1'b1, bb_en)
    `CHK("bb_config", 2'h2, bb_cfg)
    `CHK("power_sw", 4'h6, psw)
    `CHK("oe_i2c", 4'h8, poe)
    `CHK("mode_drive", 1'b1, pdrv[3])
    boot(5'h10, 1'b0);
    `CHK("bb_off", 1'b0, bb_en)
    `CHK("bb_config0", 2'h0, bb_cfg)
    `CHK("power_sw_n", 4'h9, psw)
    $display("test i2c done");
  endtask : test_i2c
  task automatic test_smbus_status;
    boot(5'h07, 1'b1);
    `CHK("smbus_mode", 1'b0, i2c)
    `CHK("bb_host", 1'b1, bb_en)
    `CHK("cfg_host", 2'h1, bb_cfg)
    `CHK("ganged", 1'b1, gang)
    `CHK("full_auto", 1'b1, fa)
    `CHK("no_switch", 1'b0, psd)
    `CHK("auto_en_n", 1'b1, aen)
    `CHK("oe_all", 4'hf, poe)
    `CHK("status_a", 4'ha, pdrv)
    @(posedge clk);
    up      <= 4'h5;
    host_bb <= 1'b0;
    tick(3);
    `CHK("status_b", 4'h5, pdrv)
    `CHK("bb_host_off", 1'b0, bb_en)
    @(posedge clk);
    up <= 4'h4;
    tick(3);
    `CHK("hs_connect", 1'b1, pdrv[2])
    `CHK("ss_suspend", 1'b0, pdrv[3])
    @(posedge clk);
    sts_en <= 1'b0;
    tick(3);
    `CHK("oe_disabled", 4'h0, poe)
    $display("test smbus status done");
  endtask : test_smbus_status
  task automatic test_smbus_override;
    boot(5'h0a, 1'b0);
    `CHK("ganged_ind", 1'b0, gang)
    `CHK("switch_off", 1'b1, psd)
    `CHK("fa_kept0", 1'b0, fa)
    `CHK("aen_strap", 1'b0, aen)
    @(posedge clk);
    we <= 4'hf;
    wd <= 4'hd;
    @(posedge clk);
    we <= 4'h1;
    wd <= 4'h0;
    @(posedge clk);
    we <= 4'h0;
    tick(2);
    `CHK("ganged_wr", 1'b1, gang)
    `CHK("fa_wr", 1'b1, fa)
    `CHK("switch_wr", 1'b0, psd)
    `CHK("aen_wr", 1'b0, aen)
    $display("test smbus override done");
  endtask : test_smbus_override
  initial begin
    rst = 1'b1; strap = 5'h1f; sts_en = 1'b1; chg = 1'b0; host_bb = 1'b1;
    host_cfg = 2'h1; we = 4'h0; wd = 4'h0; pwr_req = 4'h6; up = 4'ha;
    failures = 0; checks_done = 0;
    test_i2c();
    test_smbus_status();
    @(posedge clk);
    sts_en <= 1'b1;
    host_bb <= 1'b1;
    up <= 4'ha;
    test_smbus_override();
    final_report();
  end
endmodule : tb_hsp_strap_pins
